// [pmc_pkg.sv]
package pmc_pkg;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 8;
   localparam logic [5:0] DS_THRESH_ADDR = 6'h0A;
   localparam logic [5:0] OFFLINE_DIAG_ADDR = 6'h0B;
   localparam logic [5:0] SUPPLY_MON_ADDR = 6'h0C;
   localparam logic [7:0] DS_THRESH_RST = 8'hDD;
   localparam logic [7:0] OFFLINE_DIAG_RST = 8'h00;
   localparam logic [7:0] SUPPLY_MON_RST = 8'h14;
   // drain-source threshold fields
   localparam int unsigned HS_OC_MSB = 7;
   localparam int unsigned HS_OC_LSB = 4;
   localparam int unsigned LS_OC_MSB = 3;
   localparam int unsigned LS_OC_LSB = 0;
   // offline diagnostic fields
   localparam int unsigned DIAG_EN_BIT = 4;
   localparam int unsigned PULLUP_BIT = 3;
   localparam int unsigned PULLDOWN_BIT = 2;
   // supply monitor fields
   localparam int unsigned UV_MODE_BIT = 7;
   localparam int unsigned OV_MODE_MSB = 6;
   localparam int unsigned OV_MODE_LSB = 5;
   localparam int unsigned OV_DG_MSB = 4;
   localparam int unsigned OV_DG_LSB = 3;
   localparam int unsigned OV_LVL_BIT = 2;
   localparam int unsigned CP_MODE_BIT = 1;
   localparam int unsigned CP_LVL_BIT = 0;
   // overvoltage mode encodings
   localparam logic [1:0] OV_LATCHED = 2'h0;
   localparam logic [1:0] OV_AUTO = 2'h1;
   localparam logic [1:0] OV_WARN = 2'h2;
   localparam logic [1:0] OV_OFF = 2'h3;
   // deglitch times
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned DG_US_0 = 1;
   localparam int unsigned DG_US_1 = 2;
   localparam int unsigned DG_US_2 = 4;
   localparam int unsigned DG_US_3 = 8;
   localparam int unsigned DG_CNT_W = 9;
   localparam logic [8:0] DG_CYC_0 = 9'(DG_US_0 * CLK_MHZ);
   localparam logic [8:0] DG_CYC_1 = 9'(DG_US_1 * CLK_MHZ);
   localparam logic [8:0] DG_CYC_2 = 9'(DG_US_2 * CLK_MHZ);
   localparam logic [8:0] DG_CYC_3 = 9'(DG_US_3 * CLK_MHZ);
endpackage : pmc_pkg

// [pmc_sync.sv]
`timescale 1ns/1ns
// three-stage synchroniser; a change counts once stages two and three agree
module pmc_sync (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic asyncIn,
   output logic syncOut
);
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic out_reg;
   logic out_next;

   always_comb begin
      stage_next = {stage_reg[1:0], asyncIn};
      out_next = out_reg;
      if (stage_reg[2] == stage_reg[1]) begin
         out_next = stage_reg[2];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage_reg <= 3'h0;
         out_reg <= 1'b0;
      end else begin
         stage_reg <= stage_next;
         out_reg <= out_next;
      end
   end

   assign syncOut = out_reg;
endmodule : pmc_sync

// [pmc_config.sv]
`timescale 1ns/1ns
// Operation
// R1 - high-side threshold nibble, reset code 1 V
// R2 - low-side threshold nibble, same encoding, 1 V
// R3 - offline diagnostic enable, reset disabled
// R4 - enable sets real-time monitoring, current sources
// R5 - pull-up source needs bit and enable
// R6 - pull-down source needs bit and enable
// R7 - supply undervoltage mode: latched or auto
// R8 - overvoltage mode: latch, auto, warn, off
// R9 - overvoltage deglitch 1/2/4/8 us, reset 4
// R10 - overvoltage threshold 21.5/28.5 V, reset 28.5
// R11 - pump undervoltage mode: latched or auto
// R12 - pump threshold 2.5/5 V, reset 2.5
// R13 - register resets DDh, 00h, 14h
// R14 - latched holds until clear; auto clears
// R15 - reserved diagnostic bits are plain storage
module pmc_config (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic regWrite,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic faultClear,
   input wire logic supplyUvCmp,
   input wire logic supplyOvCmp,
   input wire logic pumpUvCmp,
   output logic [3:0] highSideOcThreshold,
   output logic [3:0] lowSideOcThreshold,
   output logic realTimeMonitor,
   output logic bridge1PullupOn,
   output logic bridge1PulldownOn,
   output logic supplyOvThreshold,
   output logic pumpUvThreshold,
   output logic supplyUvFault,
   output logic supplyOvFault,
   output logic supplyOvWarn,
   output logic pumpUvFault
);
   logic [7:0] dsThresh_reg;
   logic [7:0] dsThresh_next;
   logic [7:0] diag_reg;
   logic [7:0] diag_next;
   logic [7:0] supply_reg;
   logic [7:0] supply_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [8:0] dgCnt_reg;
   logic [8:0] dgCnt_next;
   logic ovQual_reg;
   logic ovQual_next;
   logic uvFault_reg;
   logic uvFault_next;
   logic ovFault_reg;
   logic ovFault_next;
   logic ovWarn_reg;
   logic ovWarn_next;
   logic cpFault_reg;
   logic cpFault_next;
   logic [3:0] hsOut_reg;
   logic [3:0] lsOut_reg;
   logic rtm_reg;
   logic pu_reg;
   logic pd_reg;
   logic ovLvl_reg;
   logic cpLvl_reg;
   logic uvSync;
   logic ovSync;
   logic cpSync;
   logic [1:0] ovMode;
   logic [8:0] dgLimit;

   pmc_sync uvSyncInst (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(supplyUvCmp),
      .syncOut(uvSync)
   );
   pmc_sync ovSyncInst (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(supplyOvCmp),
      .syncOut(ovSync)
   );
   pmc_sync cpSyncInst (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(pumpUvCmp),
      .syncOut(cpSync)
   );

   // response of a mode-selected monitor: set wins over clear
   function automatic logic faultNext(input logic cur, input logic cond, input logic auto,
                                      input logic clr);
      logic res;
      res = cur;
      if (cond) begin
         res = 1'b1;
      end else if (auto || clr) begin
         res = 1'b0;
      end
      return res;
   endfunction : faultNext

   // register file
   always_comb begin
      dsThresh_next = dsThresh_reg;
      diag_next = diag_reg;
      supply_next = supply_reg;
      if (regWrite) begin
         unique case (regAddr)
            pmc_pkg::DS_THRESH_ADDR: dsThresh_next = regWdata; // R1 R2
            pmc_pkg::OFFLINE_DIAG_ADDR: diag_next = regWdata; // R3 R15
            pmc_pkg::SUPPLY_MON_ADDR: supply_next = regWdata; // R7 R8 R9 R10 R11 R12
            default: ;
         endcase
      end
      unique case (regAddr)
         pmc_pkg::DS_THRESH_ADDR: rdata_next = dsThresh_reg;
         pmc_pkg::OFFLINE_DIAG_ADDR: rdata_next = diag_reg; // R15
         pmc_pkg::SUPPLY_MON_ADDR: rdata_next = supply_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dsThresh_reg <= pmc_pkg::DS_THRESH_RST; // R13
         diag_reg <= pmc_pkg::OFFLINE_DIAG_RST; // R3 R13
         supply_reg <= pmc_pkg::SUPPLY_MON_RST; // R13
         rdata_reg <= 8'h00;
      end else begin
         dsThresh_reg <= dsThresh_next;
         diag_reg <= diag_next;
         supply_reg <= supply_next;
         rdata_reg <= rdata_next;
      end
   end

   // overvoltage deglitch and fault responses
   assign ovMode = supply_reg[pmc_pkg::OV_MODE_MSB:pmc_pkg::OV_MODE_LSB];

   always_comb begin
      unique case (supply_reg[pmc_pkg::OV_DG_MSB:pmc_pkg::OV_DG_LSB]) // R9
         2'h0: dgLimit = pmc_pkg::DG_CYC_0;
         2'h1: dgLimit = pmc_pkg::DG_CYC_1;
         2'h2: dgLimit = pmc_pkg::DG_CYC_2;
         2'h3: dgLimit = pmc_pkg::DG_CYC_3;
      endcase
      dgCnt_next = 9'h000;
      ovQual_next = 1'b0;
      if (ovSync && ovMode != pmc_pkg::OV_OFF) begin
         if (dgCnt_reg >= dgLimit) begin
            dgCnt_next = dgCnt_reg;
            ovQual_next = 1'b1; // R9
         end else begin
            dgCnt_next = dgCnt_reg + 9'h001;
         end
      end
      uvFault_next = faultNext(uvFault_reg, uvSync,
                               supply_reg[pmc_pkg::UV_MODE_BIT], faultClear); // R7 R14
      cpFault_next = faultNext(cpFault_reg, cpSync,
                               supply_reg[pmc_pkg::CP_MODE_BIT], faultClear); // R11 R14
      ovFault_next = 1'b0;
      ovWarn_next = 1'b0;
      unique case (ovMode) // R8
         pmc_pkg::OV_LATCHED: ovFault_next = faultNext(ovFault_reg, ovQual_reg, 1'b0,
                                                       faultClear); // R14
         pmc_pkg::OV_AUTO: ovFault_next = faultNext(ovFault_reg, ovQual_reg, 1'b1,
                                                    faultClear); // R14
         pmc_pkg::OV_WARN: ovWarn_next = faultNext(ovWarn_reg, ovQual_reg, 1'b0, faultClear);
         pmc_pkg::OV_OFF: ;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         dgCnt_reg <= 9'h000;
         ovQual_reg <= 1'b0;
         uvFault_reg <= 1'b0;
         ovFault_reg <= 1'b0;
         ovWarn_reg <= 1'b0;
         cpFault_reg <= 1'b0;
      end else begin
         dgCnt_reg <= dgCnt_next;
         ovQual_reg <= ovQual_next;
         uvFault_reg <= uvFault_next;
         ovFault_reg <= ovFault_next;
         ovWarn_reg <= ovWarn_next;
         cpFault_reg <= cpFault_next;
      end
   end

   // registered control outputs to the analog side
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hsOut_reg <= pmc_pkg::DS_THRESH_RST[pmc_pkg::HS_OC_MSB:pmc_pkg::HS_OC_LSB];
         lsOut_reg <= pmc_pkg::DS_THRESH_RST[pmc_pkg::LS_OC_MSB:pmc_pkg::LS_OC_LSB];
         rtm_reg <= 1'b0;
         pu_reg <= 1'b0;
         pd_reg <= 1'b0;
         ovLvl_reg <= pmc_pkg::SUPPLY_MON_RST[pmc_pkg::OV_LVL_BIT];
         cpLvl_reg <= pmc_pkg::SUPPLY_MON_RST[pmc_pkg::CP_LVL_BIT];
      end else begin
         hsOut_reg <= dsThresh_reg[pmc_pkg::HS_OC_MSB:pmc_pkg::HS_OC_LSB]; // R1
         lsOut_reg <= dsThresh_reg[pmc_pkg::LS_OC_MSB:pmc_pkg::LS_OC_LSB]; // R2
         rtm_reg <= diag_reg[pmc_pkg::DIAG_EN_BIT]; // R4
         pu_reg <= diag_reg[pmc_pkg::PULLUP_BIT] & diag_reg[pmc_pkg::DIAG_EN_BIT]; // R5
         pd_reg <= diag_reg[pmc_pkg::PULLDOWN_BIT] & diag_reg[pmc_pkg::DIAG_EN_BIT]; // R6
         ovLvl_reg <= supply_reg[pmc_pkg::OV_LVL_BIT]; // R10
         cpLvl_reg <= supply_reg[pmc_pkg::CP_LVL_BIT]; // R12
      end
   end

   assign regRdata = rdata_reg;
   assign highSideOcThreshold = hsOut_reg;
   assign lowSideOcThreshold = lsOut_reg;
   assign realTimeMonitor = rtm_reg;
   assign bridge1PullupOn = pu_reg;
   assign bridge1PulldownOn = pd_reg;
   assign supplyOvThreshold = ovLvl_reg;
   assign pumpUvThreshold = cpLvl_reg;
   assign supplyUvFault = uvFault_reg;
   assign supplyOvFault = ovFault_reg;
   assign supplyOvWarn = ovWarn_reg;
   assign pumpUvFault = cpFault_reg;
endmodule : pmc_config

// [pmc_config_properties.sv]
`timescale 1ns/1ns
module pmc_config_properties (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic regWrite,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic supplyUvCmp,
   input wire logic supplyOvCmp,
   input wire logic pumpUvCmp,
   input wire logic [3:0] highSideOcThreshold,
   input wire logic [3:0] lowSideOcThreshold,
   input wire logic realTimeMonitor,
   input wire logic bridge1PullupOn,
   input wire logic bridge1PulldownOn,
   input wire logic supplyOvThreshold,
   input wire logic pumpUvThreshold,
   input wire logic supplyUvFault,
   input wire logic supplyOvFault,
   input wire logic supplyOvWarn,
   input wire logic pumpUvFault
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   pullup_gate_a:
      assert property (bridge1PullupOn |-> realTimeMonitor) else $error("pull-up on without enable");
   pulldown_gate_a:
      assert property (bridge1PulldownOn |-> realTimeMonitor) else $error("pull-down without enable");
   threshold_write_a:
      assert property (regWrite && regAddr == pmc_pkg::DS_THRESH_ADDR |-> ##2
         {highSideOcThreshold, lowSideOcThreshold} == $past(regWdata, 2))
      else $error("threshold outputs miss write");
   diag_write_a:
      assert property (regWrite && regAddr == pmc_pkg::OFFLINE_DIAG_ADDR |-> ##2
         realTimeMonitor == $past(regWdata[4], 2)) else $error("monitor mode misses write");
   level_write_a:
      assert property (regWrite && regAddr == pmc_pkg::SUPPLY_MON_ADDR |-> ##2
         {supplyOvThreshold, pumpUvThreshold} == {$past(regWdata[2], 2), $past(regWdata[0], 2)})
      else $error("supply levels miss write");
   readback_match_a:
      assert property (regAddr == pmc_pkg::DS_THRESH_ADDR && $stable(regAddr) && $past(reset_n)
         |-> regRdata == {highSideOcThreshold, lowSideOcThreshold})
      else $error("read data differs from thresholds");
   supply_uv_set_a:
      assert property (supplyUvCmp [*6] |-> ##[0:4] supplyUvFault) else $error("no supply fault");
   pump_uv_set_a:
      assert property (pumpUvCmp [*6] |-> ##[0:4] pumpUvFault) else $error("no pump fault");
   ov_deglitch_a:
      assert property ($rose(supplyOvFault) |-> $past(supplyOvCmp, 50))
      else $error("overvoltage fault too early");
   cover property (bridge1PullupOn && !bridge1PulldownOn);
   cover property ($fell(supplyUvFault));
   cover property ($rose(supplyOvWarn));
endmodule : pmc_config_properties

bind pmc_config pmc_config_properties i_props (.*);

// [pmc_config_tb.sv]
`timescale 1ns/1ns
module pmc_config_tb;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic regWrite = 1'b0;
   logic [5:0] regAddr = 6'h00;
   logic [7:0] regWdata = 8'h00;
   logic faultClear = 1'b0;
   logic supplyUvCmp = 1'b0;
   logic supplyOvCmp = 1'b0;
   logic pumpUvCmp = 1'b0;
   logic [7:0] regRdata;
   logic [3:0] highSideOcThreshold, lowSideOcThreshold;
   logic realTimeMonitor, bridge1PullupOn, bridge1PulldownOn, supplyOvThreshold, pumpUvThreshold;
   logic supplyUvFault, supplyOvFault, supplyOvWarn, pumpUvFault;
   int failures = 0;
   int cmp_count = 0;
   // deglitch length of each code, 1/2/4/8 us at 50 MHz
   int dgCycles[4] = '{pmc_pkg::DG_CYC_0, pmc_pkg::DG_CYC_1,
                       pmc_pkg::DG_CYC_2, pmc_pkg::DG_CYC_3};
   wire [7:0] thr = {highSideOcThreshold, lowSideOcThreshold};
   wire [7:0] diag = {5'h00, realTimeMonitor, bridge1PullupOn, bridge1PulldownOn};
   wire [7:0] flt = {4'h0, supplyUvFault, supplyOvFault, supplyOvWarn, pumpUvFault};

   pmc_config i_dut (.*);

   always #10 ref_clk = ~ref_clk;

   task automatic end_sim;
      if (failures == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : wt

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      wt(2);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      regAddr <= a;
      @(posedge ref_clk);
      wt(1);
      chk(regRdata, exp);
   endtask : rd

   task automatic clr;
      @(posedge ref_clk);
      faultClear <= 1'b1;
      @(posedge ref_clk);
      faultClear <= 1'b0;
      wt(2);
   endtask : clr

   // both undervoltage comparators move together
   task automatic uv(input logic lvl);
      @(posedge ref_clk);
      supplyUvCmp <= lvl;
      pumpUvCmp <= lvl;
      wt(10);
   endtask : uv

   initial begin
      #1000000;
      failures++;
      end_sim();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      wt(1);
      chk(thr, 8'hDD);
      chk({6'h00, supplyOvThreshold, pumpUvThreshold}, 8'h02);
      chk(diag, 8'h00);
      rd(pmc_pkg::DS_THRESH_ADDR, 8'hDD);
      rd(pmc_pkg::OFFLINE_DIAG_ADDR, 8'h00);
      rd(pmc_pkg::SUPPLY_MON_ADDR, 8'h14);
      wr(pmc_pkg::OFFLINE_DIAG_ADDR, 8'h0C);
      chk(diag, 8'h00);
      wr(pmc_pkg::OFFLINE_DIAG_ADDR, 8'hFB);
      chk(diag, 8'h06);
      rd(pmc_pkg::OFFLINE_DIAG_ADDR, 8'hFB);
      wr(pmc_pkg::OFFLINE_DIAG_ADDR, 8'h14);
      chk(diag, 8'h05);
      wr(pmc_pkg::DS_THRESH_ADDR, 8'h7F);
      chk(thr, 8'h7F);
      wr(6'h0D, 8'hFF);
      rd(6'h0D, 8'h00);
      rd(pmc_pkg::DS_THRESH_ADDR, 8'h7F);
      wr(pmc_pkg::SUPPLY_MON_ADDR, 8'h11);
      chk({6'h00, supplyOvThreshold, pumpUvThreshold}, 8'h01);
      uv(1'b1);
      chk(flt, 8'h09);
      uv(1'b0);
      chk(flt, 8'h09);
      clr();
      chk(flt, 8'h00);
      wr(pmc_pkg::SUPPLY_MON_ADDR, 8'h82);
      uv(1'b1);
      chk(flt, 8'h09);
      uv(1'b0);
      chk(flt, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(pmc_pkg::SUPPLY_MON_ADDR, {1'b0, m[1:0], 5'h00});
         clr();
         @(posedge ref_clk);
         supplyOvCmp <= 1'b1;
         wt(40);
         chk(flt, 8'h00);
         wt(30);
         chk(flt, {5'h00, m < 2, m == 2, 1'b0});
         @(posedge ref_clk);
         supplyOvCmp <= 1'b0;
         wt(10);
         chk(flt, {5'h00, m == 0, m == 2, 1'b0});
      end
      // every deglitch code, latched mode, checked just before and just after qualification
      for (int c = 0; c < 4; c++) begin
         wr(pmc_pkg::SUPPLY_MON_ADDR, {3'h0, c[1:0], 3'h0});
         clr();
         @(posedge ref_clk);
         supplyOvCmp <= 1'b1;
         wt(dgCycles[c] + 5);
         chk(flt, 8'h00);
         wt(3);
         chk(flt, 8'h04);
         @(posedge ref_clk);
         supplyOvCmp <= 1'b0;
         wt(10);
      end
      end_sim();
   end
endmodule : pmc_config_tb
